// file: shared/rpm_pkg.sv
// constants, field layout and types of the backup-pin output mux
package rpm_pkg;

    // register byte offsets
    localparam logic [31:0] REG_CTRL_ADDR = 32'h0000_0000;
    localparam logic [31:0] REG_STAT_ADDR = 32'h0000_0004;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    // control_reg fields
    localparam int CTL_SEL_LSB = 0;
    localparam int CTL_SEL_MSB = 1;
    localparam int CTL_TAMP_OE = 2;
    localparam int CTL_CAL_OE = 3;
    localparam int CTL_CAL_1HZ = 4;
    localparam int CTL_OUT2 = 5;
    localparam int CTL_OD = 6;
    localparam int CTL_PU = 7;
    localparam int CTL_TAMP_IN = 8;
    localparam int CTL_TS_IN = 9;
    localparam int CTL_MSB = 9;

    // status fields
    localparam int ST_MODE_LSB = 0;
    localparam int ST_MODE_MSB = 1;
    localparam int ST_PIN = 2;
    localparam int ST_COMB = 3;
    localparam int ST_CAL = 4;
    localparam int ST_MSB = 4;

    // AHB-Lite codes
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // kernel clock and calibration rates
    localparam int KERNEL_HZ = 32768;
    localparam int CAL_FAST_HZ = 512;
    localparam int CAL_SLOW_HZ = 1;

    typedef enum logic [1:0] {
        SEL_OFF = 2'b00,
        SEL_ALARM_A = 2'b01,
        SEL_ALARM_B = 2'b10,
        SEL_WAKEUP = 2'b11
    } rpm_sel_t;

    typedef enum logic [1:0] {
        MODE_INPUT = 2'b00,
        MODE_COMB_PP = 2'b01,
        MODE_COMB_OD = 2'b10,
        MODE_CAL_PP = 2'b11
    } rpm_mode_t;

endpackage : rpm_pkg

// file: shared/rpm_div_if.sv
// link between the pin mux and its calibration divider
`timescale 1ns/1ps
interface rpm_div_if;
    logic kernel_tick;
    logic run;
    logic slow;
    logic cal_level;

    modport ctl (output kernel_tick, output run, output slow, input cal_level);
    modport div (input kernel_tick, input run, input slow, output cal_level);
endinterface : rpm_div_if

// file: rtl/rpm_cal_div.sv
// calibration clock divider counting kernel clock edges
`timescale 1ns/1ps
module rpm_cal_div
    import rpm_pkg::*;
#(
    parameter int KER_HZ = KERNEL_HZ
) (
    input wire logic sys_clk,
    input wire logic rstn,
    rpm_div_if.div dv
);
    localparam int FAST_HALF = KER_HZ / (2 * CAL_FAST_HZ);
    localparam int SLOW_HALF = KER_HZ / (2 * CAL_SLOW_HZ);
    localparam int CNT_W = $clog2(SLOW_HALF + 1);
    localparam logic [CNT_W-1:0] FAST_LAST = CNT_W'(FAST_HALF - 1);
    localparam logic [CNT_W-1:0] SLOW_LAST = CNT_W'(SLOW_HALF - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] last;

    assign last = dv.slow ? SLOW_LAST : FAST_LAST;

    always_ff @(posedge sys_clk) begin
        if (!rstn || !dv.run) begin
            count <= CNT_ZERO;
            dv.cal_level <= 1'b0;
        end else if (dv.kernel_tick) begin
            if (count >= last) begin
                count <= CNT_ZERO;
                dv.cal_level <= ~dv.cal_level;
            end else begin
                count <= count + CNT_ONE;
            end
        end
    end

    property p_cal_stop;
        @(posedge sys_clk) disable iff (!rstn)
        !dv.run |=> !dv.cal_level;
    endproperty
    a_cal_stops_off: assert property (p_cal_stop) else $error("cal clock runs while disabled");

    property p_cal_half;
        @(posedge sys_clk) disable iff (!rstn)
        (dv.run && dv.kernel_tick && count == last) ##1 dv.run |-> dv.cal_level != $past(dv.cal_level);
    endproperty
    a_cal_half_period: assert property (p_cal_half) else $error("cal clock missed its toggle");

endmodule : rpm_cal_div

// file: rtl/rpm_top.sv
// backup-pin output mux: combined alarm/tamper, calibration clock and pin input routing
// Overview of operation
// - combined output is tamper OR alarm
// - calibration clock 512 Hz or 1 Hz
// - calibration clock only when enabled
// - select routes alarm A, B, wakeup; 00 off
// - tamper enable adds tamper events to output
// - active combined output push-pull by default
// - open-drain option with optional pull-up
// - calibration drives pin only when unclaimed
// - idle pin floats, feeds tamper/timestamp inputs
// - priority: combined, calibration, then inputs
// - device owns backup pin over GPIO setup
// - shared pin works in every power mode
// - accept timestamp pin and reference clock
// - accept internal power-loss timestamp event
// - accept tamper event from tamper unit
// - separate alarm A, B, wakeup triggers
// - calendar overflow goes to tamper source five
// - separate kernel clock and interrupt output
`timescale 1ns/1ps
module rpm_top
    import rpm_pkg::*;
#(
    parameter int KER_HZ = KERNEL_HZ
) (
    input wire logic sys_clk,
    input wire logic rstn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // kernel clock, sampled as a level
    input wire logic kernel_clk,
    // events from the timekeeping core and neighbours
    input wire logic alarm_a_evt,
    input wire logic alarm_b_evt,
    input wire logic wakeup_evt,
    input wire logic calendar_ovf,
    input wire logic core_irq,
    input wire logic power_loss_ts,
    input wire logic tamper_evt,
    input wire logic ref_clock_pin,
    // shared backup pin
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    output logic pin_pullup,
    output logic pin_owned,
    // results
    output logic alarm_tamper_out,
    output logic cal_clock_out,
    output logic timestamp_pin,
    output logic tamper_in_pin,
    output logic timestamp_evt,
    output logic ref_clock_level,
    output logic alarm_a_trg,
    output logic alarm_b_trg,
    output logic wakeup_trg,
    output logic internal_tamper_src5,
    output logic irq_out
);
    logic [CTL_MSB:0] control_reg;
    logic wr_pend;
    logic [31:0] wr_addr;
    logic addr_ok;
    logic [31:0] rd_word;
    logic [CTL_MSB:0] eff_ctrl;
    logic kernel_prev;
    logic alarm_a_prev;
    logic alarm_b_prev;
    logic wakeup_prev;
    logic ts_pin_prev;
    logic alarm_sel_out;
    logic next_combined;
    logic comb_claim;
    logic cal_claim;
    rpm_mode_t next_mode;
    rpm_mode_t pin_mode;
    logic next_pin_out;
    logic next_pin_oe;
    logic next_pin_pullup;
    rpm_sel_t alarm_out_sel;
    logic tamper_out_en;
    logic cal_out_en;
    logic second_out_en;
    logic combined_out_opendrain;
    logic combined_out_pullup;
    logic tamper_in_en;
    logic timestamp_in_en;

    rpm_div_if div_bus ();

    rpm_cal_div #(
        .KER_HZ(KER_HZ)
    ) u_div (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .dv(div_bus.div)
    );

    assign alarm_out_sel = rpm_sel_t'(control_reg[CTL_SEL_MSB:CTL_SEL_LSB]);
    assign tamper_out_en = control_reg[CTL_TAMP_OE];
    assign cal_out_en = control_reg[CTL_CAL_OE];
    assign second_out_en = control_reg[CTL_OUT2];
    assign combined_out_opendrain = control_reg[CTL_OD];
    assign combined_out_pullup = control_reg[CTL_PU];
    assign tamper_in_en = control_reg[CTL_TAMP_IN];
    assign timestamp_in_en = control_reg[CTL_TS_IN];

    // AHB-Lite slave
    // zero wait states; every transfer answers OKAY, unmapped reads return zero
    assign addr_ok = hsel && hready && htrans == HTRANS_NONSEQ && hsize == HSIZE_WORD;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            wr_pend <= 1'b0;
            wr_addr <= WORD_ZERO;
        end else begin
            wr_pend <= addr_ok && hwrite;
            wr_addr <= haddr;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            control_reg <= CTRL_RESET[CTL_MSB:0];
        end else if (wr_pend && wr_addr == REG_CTRL_ADDR) begin
            control_reg <= hwdata[CTL_MSB:0];
        end
    end

    // a read right behind a write to the same register sees the new value
    assign eff_ctrl = (wr_pend && wr_addr == REG_CTRL_ADDR) ? hwdata[CTL_MSB:0] : control_reg;

    always_comb begin
        rd_word = WORD_ZERO;
        if (haddr == REG_CTRL_ADDR) begin
            rd_word[CTL_MSB:0] = eff_ctrl;
        end else if (haddr == REG_STAT_ADDR) begin
            rd_word[ST_MODE_MSB:ST_MODE_LSB] = pin_mode;
            rd_word[ST_PIN] = pin_in;
            rd_word[ST_COMB] = alarm_tamper_out;
            rd_word[ST_CAL] = cal_clock_out;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            hrdata <= WORD_ZERO;
        end else if (addr_ok && !hwrite) begin
            hrdata <= rd_word;
        end
    end

    // kernel clock and calibration
    // kernel clock rising edges drive the calibration divider
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            kernel_prev <= 1'b0;
        end else begin
            kernel_prev <= kernel_clk;
        end
    end

    assign div_bus.kernel_tick = kernel_clk && !kernel_prev;
    assign div_bus.run = cal_out_en;
    assign div_bus.slow = control_reg[CTL_CAL_1HZ];

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            cal_clock_out <= 1'b0;
        end else begin
            cal_clock_out <= div_bus.cal_level && cal_out_en;
        end
    end

    // combined alarm/tamper
    // alarm source select
    always_comb begin
        unique case (alarm_out_sel)
            SEL_OFF: alarm_sel_out = 1'b0;
            SEL_ALARM_A: alarm_sel_out = alarm_a_evt;
            SEL_ALARM_B: alarm_sel_out = alarm_b_evt;
            SEL_WAKEUP: alarm_sel_out = wakeup_evt;
        endcase
    end

    assign next_combined = alarm_sel_out || (tamper_out_en && tamper_evt);

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            alarm_tamper_out <= 1'b0;
        end else begin
            alarm_tamper_out <= next_combined;
        end
    end

    // pin function selection
    assign comb_claim = alarm_out_sel != SEL_OFF || tamper_out_en;
    assign cal_claim = cal_out_en && !second_out_en;

    always_comb begin
        if (comb_claim) begin
            next_mode = combined_out_opendrain ? MODE_COMB_OD : MODE_COMB_PP;
        end else if (cal_claim) begin
            next_mode = MODE_CAL_PP;
        end else begin
            next_mode = MODE_INPUT;
        end
    end

    always_comb begin
        next_pin_out = 1'b0;
        next_pin_oe = 1'b0;
        next_pin_pullup = 1'b0;
        unique case (next_mode)
            MODE_COMB_PP: begin
                next_pin_out = next_combined;
                next_pin_oe = 1'b1;
            end
            MODE_COMB_OD: begin
                next_pin_oe = next_combined;
                next_pin_pullup = combined_out_pullup;
            end
            MODE_CAL_PP: begin
                next_pin_out = div_bus.cal_level;
                next_pin_oe = 1'b1;
            end
            MODE_INPUT: begin
            end
        endcase
    end

    // no power-mode gating here, so the pin keeps working in low-power and battery mode
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            pin_mode <= MODE_INPUT;
            pin_out <= 1'b0;
            pin_oe <= 1'b0;
            pin_pullup <= 1'b0;
            pin_owned <= 1'b0;
        end else begin
            pin_mode <= next_mode;
            pin_out <= next_pin_out;
            pin_oe <= next_pin_oe;
            pin_pullup <= next_pin_pullup;
            pin_owned <= 1'b1;
        end
    end

    // inputs from the pin and neighbours
    // pin feeds enabled inputs
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            ts_pin_prev <= 1'b0;
            timestamp_pin <= 1'b0;
            tamper_in_pin <= 1'b0;
            timestamp_evt <= 1'b0;
            ref_clock_level <= 1'b0;
        end else begin
            ts_pin_prev <= pin_in;
            timestamp_pin <= (next_mode == MODE_INPUT) && timestamp_in_en && pin_in;
            tamper_in_pin <= (next_mode == MODE_INPUT) && tamper_in_en && pin_in;
            // a pin edge is only counted while the pin is really an input
            timestamp_evt <= power_loss_ts
                || ((next_mode == MODE_INPUT) && timestamp_in_en && pin_in && !ts_pin_prev);
            ref_clock_level <= ref_clock_pin;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            alarm_a_prev <= 1'b0;
            alarm_b_prev <= 1'b0;
            wakeup_prev <= 1'b0;
            alarm_a_trg <= 1'b0;
            alarm_b_trg <= 1'b0;
            wakeup_trg <= 1'b0;
        end else begin
            alarm_a_prev <= alarm_a_evt;
            alarm_b_prev <= alarm_b_evt;
            wakeup_prev <= wakeup_evt;
            alarm_a_trg <= alarm_a_evt && !alarm_a_prev;
            alarm_b_trg <= alarm_b_evt && !alarm_b_prev;
            wakeup_trg <= wakeup_evt && !wakeup_prev;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            internal_tamper_src5 <= 1'b0;
            irq_out <= 1'b0;
        end else begin
            internal_tamper_src5 <= calendar_ovf;
            irq_out <= core_irq;
        end
    end

    // assertions
    sequence s_cfg_pp;
        comb_claim && !combined_out_opendrain && !combined_out_pullup;
    endsequence
    sequence s_cfg_od;
        comb_claim && combined_out_opendrain;
    endsequence
    sequence s_cfg_cal;
        !comb_claim && cal_out_en && !second_out_en;
    endsequence
    sequence s_cfg_idle;
        !comb_claim && !cal_claim;
    endsequence

    a_comb_tamper_or: assert property (@(posedge sys_clk) disable iff (!rstn)
        tamper_out_en && tamper_evt |=> alarm_tamper_out) else $error("tamper event missing on output");
    a_comb_alarm_route: assert property (@(posedge sys_clk) disable iff (!rstn)
        alarm_out_sel == SEL_ALARM_B && alarm_b_evt |=> alarm_tamper_out) else $error("alarm B not routed");
    a_comb_all_off: assert property (@(posedge sys_clk) disable iff (!rstn)
        !comb_claim |=> !alarm_tamper_out) else $error("combined output active while disabled");
    a_pin_push_pull: assert property (@(posedge sys_clk) disable iff (!rstn)
        s_cfg_pp |=> pin_oe && pin_out == alarm_tamper_out && !pin_pullup) else $error("push-pull drive wrong");
    a_pin_open_drain: assert property (@(posedge sys_clk) disable iff (!rstn)
        s_cfg_od |=> !pin_out && pin_oe == alarm_tamper_out && pin_pullup == $past(combined_out_pullup))
        else $error("open-drain drive wrong");
    a_pin_cal_drive: assert property (@(posedge sys_clk) disable iff (!rstn)
        s_cfg_cal |=> pin_oe && pin_out == cal_clock_out && pin_mode == MODE_CAL_PP)
        else $error("calibration drive wrong");
    a_pin_input_float: assert property (@(posedge sys_clk) disable iff (!rstn)
        s_cfg_idle |=> !pin_oe && !pin_pullup && pin_mode == MODE_INPUT) else $error("idle pin not floating");
    a_trig_one_cycle: assert property (@(posedge sys_clk) disable iff (!rstn)
        alarm_a_trg |=> !alarm_a_trg) else $error("trigger longer than one cycle");
    a_calovf_forward: assert property (@(posedge sys_clk) disable iff (!rstn)
        calendar_ovf |=> internal_tamper_src5) else $error("overflow not forwarded");
endmodule : rpm_top

// file: verification/rpm_pin_model.sv
// model of the circuitry around the shared backup pin
`timescale 1ns/1ps
module rpm_pin_model (
    input wire logic sys_clk,
    input wire logic pin_out,
    input wire logic pin_oe,
    input wire logic pin_pullup,
    input wire logic ext_en,
    input wire logic ext_val,
    output logic pin_level
);
    // an undriven pin with no pull wanders, so nothing can rely on a held value
    logic float_q = 1'b0;

    always @(posedge sys_clk) begin
        float_q <= ~float_q;
    end

    always_comb begin
        if (pin_oe) begin
            pin_level = pin_out;
        end else if (ext_en) begin
            pin_level = ext_val;
        end else if (pin_pullup) begin
            pin_level = 1'b1;
        end else begin
            pin_level = float_q;
        end
    end
endmodule : rpm_pin_model

// file: verification/tb_rtc_pin_output_mux.sv
// self-checking bench for the backup-pin output mux
`timescale 1ns/1ps
module tb_rtc_pin_output_mux
    import rpm_pkg::*;
;
    localparam int KHZ = 2048;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = WORD_ZERO;
    logic [31:0] hwdata = WORD_ZERO;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = HSIZE_WORD;
    logic hreadyout, hresp, pin_out, pin_oe, pin_pullup, pin_owned, pin_level, cal_clock_out;
    logic alarm_tamper_out, timestamp_pin, tamper_in_pin, timestamp_evt, ref_clock_level;
    logic alarm_a_trg, alarm_b_trg, wakeup_trg, internal_tamper_src5, irq_out, kernel_clk;
    logic [31:0] hrdata;
    logic [1:0] kdiv = 2'h0;
    logic kclk_run = 1'b0;
    logic ext_en = 1'b1;
    logic [8:0] ev = 9'h000;
    logic [9:0] ctrl_q = 10'h000;
    logic obs_stb = 1'b0;
    logic rd_ph = 1'b0;
    logic cal_q = 1'b0;
    logic [31:0] cal_cnt = WORD_ZERO;
    logic [14:0] obs;
    logic [31:0] rq[$], pq[$], cq[$];
    int error_cnt = 0;
    int samples_checked = 0;
    int cyc = 0;

    always #12.5 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        if (kclk_run) begin
            kdiv <= kdiv + 2'h1;
        end
    end
    assign kernel_clk = kdiv[1];
    assign obs = {hresp, pin_out, pin_oe, pin_pullup, pin_owned, alarm_tamper_out, timestamp_pin,
                  tamper_in_pin, timestamp_evt, ref_clock_level, alarm_a_trg, alarm_b_trg, wakeup_trg,
                  internal_tamper_src5, irq_out};

    rpm_top #(.KER_HZ(KHZ)) dut_u (
        .sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .kernel_clk(kernel_clk), .alarm_a_evt(ev[0]), .alarm_b_evt(ev[1]),
        .wakeup_evt(ev[2]), .calendar_ovf(ev[3]), .core_irq(ev[4]), .power_loss_ts(ev[5]),
        .tamper_evt(ev[6]), .ref_clock_pin(ev[7]), .pin_in(pin_level), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_pullup(pin_pullup), .pin_owned(pin_owned),
        .alarm_tamper_out(alarm_tamper_out), .cal_clock_out(cal_clock_out),
        .timestamp_pin(timestamp_pin), .tamper_in_pin(tamper_in_pin), .timestamp_evt(timestamp_evt),
        .ref_clock_level(ref_clock_level), .alarm_a_trg(alarm_a_trg), .alarm_b_trg(alarm_b_trg),
        .wakeup_trg(wakeup_trg), .internal_tamper_src5(internal_tamper_src5), .irq_out(irq_out)
    );

    rpm_pin_model pin_u (
        .sys_clk(sys_clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
        .ext_en(ext_en), .ext_val(ev[8]), .pin_level(pin_level)
    );

    function automatic logic [1:0] mode_f(logic [9:0] c);
        if (c[CTL_SEL_MSB:CTL_SEL_LSB] != SEL_OFF || c[CTL_TAMP_OE]) begin
            return c[CTL_OD] ? MODE_COMB_OD : MODE_COMB_PP;
        end
        if (c[CTL_CAL_OE] && !c[CTL_OUT2]) begin
            return MODE_CAL_PP;
        end
        return MODE_INPUT;
    endfunction : mode_f

    function automatic logic comb_f(logic [9:0] c, logic [8:0] e);
        logic al;
        al = (c[1:0] == SEL_ALARM_A) ? e[0] : (c[1:0] == SEL_ALARM_B) ? e[1] : (c[1:0] == SEL_WAKEUP) & e[2];
        return al | (c[CTL_TAMP_OE] & e[6]);
    endfunction : comb_f

    // the divider stays at its reset level while the kernel clock is held
    function automatic logic lvl_f(logic [9:0] c, logic [8:0] e);
        if (mode_f(c) == MODE_COMB_PP) begin
            return comb_f(c, e);
        end
        if (mode_f(c) == MODE_CAL_PP || (mode_f(c) == MODE_COMB_OD && comb_f(c, e))) begin
            return 1'b0;
        end
        return e[8];
    endfunction : lvl_f

    function automatic logic [31:0] stat_f(logic [9:0] c, logic [8:0] e);
        return {27'h0, 1'b0, comb_f(c, e), lvl_f(c, e), mode_f(c)};
    endfunction : stat_f

    function automatic logic [31:0] vec_f(logic [9:0] c, logic [8:0] e, logic [2:0] trg);
        logic [1:0] m;
        logic inp;
        m = mode_f(c);
        inp = (m == MODE_INPUT);
        return {17'h0, 1'b0, m == MODE_COMB_PP && comb_f(c, e), m == MODE_COMB_OD ? comb_f(c, e) : !inp,
                m == MODE_COMB_OD && c[CTL_PU], 1'b1, comb_f(c, e), inp & c[CTL_TS_IN] & lvl_f(c, e),
                inp & c[CTL_TAMP_IN] & lvl_f(c, e), e[5], e[7], trg, e[3], e[4]};
    endfunction : vec_f

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [2:0] sz);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= wr;
        hsize <= sz;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wr ? d : WORD_ZERO;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
    endtask : bus

    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [2:0] sz);
        if (a == REG_CTRL_ADDR && sz == HSIZE_WORD) begin
            ctrl_q = d[9:0];
        end
        bus(1'b1, a, d, sz);
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        rq.push_back(exp);
        bus(1'b0, a, WORD_ZERO, HSIZE_WORD);
    endtask : rd

    task automatic expect_pins(input int d, input logic [2:0] trg);
        repeat (d) @(posedge sys_clk);
        pq.push_back(vec_f(ctrl_q, ev, trg));
        obs_stb <= 1'b1;
        @(posedge sys_clk);
        obs_stb <= 1'b0;
    endtask : expect_pins

    always @(posedge sys_clk) begin
        if (rd_ph && hreadyout === 1'b1) begin
            check(hrdata, rq.pop_front());
        end
        if (hreadyout === 1'b1) begin
            rd_ph <= hsel && htrans == HTRANS_NONSEQ && !hwrite;
        end
        if (obs_stb) begin
            check({17'h0, obs}, pq.pop_front());
        end
        if (cal_clock_out === 1'b1 && cal_q !== 1'b1) begin
            if (cq.size() > 0) begin
                check(cal_cnt, cq.pop_front());
            end
            cal_cnt <= 32'h0000_0001;
        end else begin
            cal_cnt <= cal_cnt + 32'h0000_0001;
        end
        cal_q <= cal_clock_out;
        cyc <= cyc + 1;
        if (cyc == 50000) begin
            error_cnt++;
            print_verdict();
        end
    end

    initial begin
        void'($urandom(73));
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rd(REG_CTRL_ADDR, CTRL_RESET);
        rd(REG_STAT_ADDR, stat_f(10'h000, ev));
        expect_pins(1, 3'h0);
        // upper bits, read-only status, unmapped place, narrow write
        wr(REG_CTRL_ADDR, 32'hFFFF_FFFF, HSIZE_WORD);
        rd(REG_CTRL_ADDR, 32'h0000_03FF);
        wr(REG_STAT_ADDR, 32'hFFFF_FFFF, HSIZE_WORD);
        rd(REG_STAT_ADDR, stat_f(ctrl_q, ev));
        wr(32'h0000_0008, 32'hFFFF_FFFF, HSIZE_WORD);
        rd(32'h0000_0008, WORD_ZERO);
        wr(REG_CTRL_ADDR, WORD_ZERO, 3'h0);
        rd(REG_CTRL_ADDR, 32'h0000_03FF);
        for (int i = 0; i < 40; i++) begin
            wr(REG_CTRL_ADDR, {22'h0, 10'($urandom)}, HSIZE_WORD);
            ev <= 9'($urandom);
            expect_pins(5, 3'h0);
            rd(REG_STAT_ADDR, stat_f(ctrl_q, ev));
        end
        // open drain idle, only the pull-up holds the pin
        ext_en <= 1'b0;
        ev <= 9'h000;
        wr(REG_CTRL_ADDR, 32'h0000_00C4, HSIZE_WORD);
        repeat (4) @(posedge sys_clk);
        rd(REG_STAT_ADDR, 32'h0000_0006);
        ext_en <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            ev <= 9'h000;
            repeat (4) @(posedge sys_clk);
            ev <= 9'(1 << k);
            expect_pins(1, 3'(4 >> k));
            expect_pins(1, 3'h0);
        end
        // calibration clock at both rates, then off
        kclk_run <= 1'b1;
        wr(REG_CTRL_ADDR, 32'h0000_0008, HSIZE_WORD);
        repeat (40) @(posedge sys_clk);
        cq.push_back(32'h0000_0010);
        cq.push_back(32'h0000_0010);
        for (int j = 0; j < 100 && cq.size() > 0; j++) @(posedge sys_clk);
        check(32'(cq.size()), WORD_ZERO);
        wr(REG_CTRL_ADDR, 32'h0000_0018, HSIZE_WORD);
        repeat (12000) @(posedge sys_clk);
        cq.push_back(32'h0000_2000);
        for (int j = 0; j < 9000 && cq.size() > 0; j++) @(posedge sys_clk);
        check(32'(cq.size()), WORD_ZERO);
        wr(REG_CTRL_ADDR, WORD_ZERO, HSIZE_WORD);
        repeat (20) @(posedge sys_clk);
        rd(REG_STAT_ADDR, stat_f(ctrl_q, ev));
        repeat (3) @(posedge sys_clk);
        print_verdict();
    end
endmodule : tb_rtc_pin_output_mux
